// ==== rtl/sdx_dma.sv ====
// Descriptor DMA transfer path of an SD host, with its known transfer limits.
// Assumes an APB master on pclk and a card clock and data line zero from the card pins.
//
// Operation
// - End transfer descriptor of 1..4 bytes with block counting may stall the engine.
// - Descriptor read with block size not multiple of 4 never completes.
// - Data line active flag does not follow card busy after R1b commands.
// - Block count of one never gives an unbounded transfer, counting on or off.
`default_nettype none
module sdx_dma #(
  parameter int BLKSIZE_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Card side
  input wire logic card_clk,
  input wire logic card_dat0,
  output logic byte_strobe,
  // Interrupt
  output logic irq
);
  import sdx_pkg::*;

  initial begin
    if (BLKSIZE_W < 3 || BLKSIZE_W > 16) begin
      $error("BLKSIZE_W out of range");
    end
  end

  // ****************
  // Bus decode
  // ****************
  logic setup_phase;
  logic wr_en;
  logic rd_done;
  logic mapped;
  assign setup_phase = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pready;
  assign rd_done = psel & penable & ~pwrite & pready;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= SDX_OFF_XFER_COUNT);
  endfunction
  assign mapped = is_mapped(paddr);

  // ****************
  // Registers
  // ****************
  logic [31:0] ctrl_reg;
  logic [BLKSIZE_W-1:0] blksize_reg;
  logic [15:0] block_count_field_reg;
  sdx_desc_t desc_reg;
  logic [SDX_IRQ_W-1:0] status_reg;
  logic [SDX_IRQ_W-1:0] mask_reg;
  logic [15:0] xfer_count_reg;
  sdx_state_t state_reg;
  logic start_pulse;
  logic abort_pulse;
  assign start_pulse = wr_en && paddr == SDX_OFF_CTRL && pwdata[SDX_CTRL_START];
  assign abort_pulse = wr_en && paddr == SDX_OFF_CTRL && pwdata[SDX_CTRL_ABORT];
  // Control bits as they stand after this cycle, so a start sees its own mode bits.
  logic [31:0] ctrl_now;
  assign ctrl_now = (wr_en && paddr == SDX_OFF_CTRL)
    ? {27'h000_0000, 1'b0, pwdata[3:1], 1'b0} : ctrl_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= SDX_RST_WORD;
      blksize_reg <= BLKSIZE_W'(SDX_RST_BLKSIZE);
      block_count_field_reg <= SDX_RST_BLOCK_COUNT_FIELD;
      desc_reg <= sdx_desc_t'(SDX_RST_WORD[18:0]);
      mask_reg <= '0;
    end else if (wr_en) begin
      case (paddr)
        SDX_OFF_CTRL: ctrl_reg <= {27'h000_0000, 1'b0, pwdata[3:1], 1'b0};
        SDX_OFF_BLKSIZE: blksize_reg <= pwdata[BLKSIZE_W-1:0];
        SDX_OFF_BLOCK_COUNT_FIELD: block_count_field_reg <= pwdata[15:0];
        SDX_OFF_DESC: desc_reg <= sdx_desc_t'(pwdata[18:0]);
        SDX_OFF_IRQ_MASK: mask_reg <= pwdata[SDX_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************
  // Card pin synchronisers
  // ****************
  logic [1:0] clk_sync_reg;
  logic clk_prev_reg;
  logic [1:0] dat0_sync_reg;
  logic card_edge;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sync_reg <= 2'b00;
      clk_prev_reg <= 1'b0;
      dat0_sync_reg <= 2'b11;
    end else begin
      clk_sync_reg <= {clk_sync_reg[0], card_clk};
      clk_prev_reg <= clk_sync_reg[1];
      dat0_sync_reg <= {dat0_sync_reg[0], card_dat0};
    end
  end
  assign card_edge = clk_sync_reg[1] & ~clk_prev_reg;

  // ****************
  // Transfer engine
  // ****************
  logic [15:0] bytes_left_reg;
  logic [BLKSIZE_W-1:0] blk_byte_reg;
  logic [15:0] blk_done_reg;
  logic short_end;
  logic misaligned_read;
  logic count_limit;
  logic block_end;
  logic last_byte;
  logic set_tc;
  logic set_hazard;
  logic set_stall;

  assign short_end = desc_reg.kind == SDX_DESC_TRANSFER_DESCRIPTOR && desc_reg.last
    && desc_reg.len != 16'h0000 && desc_reg.len <= 16'(SDX_SHORT_LEN_MAX)
    && ctrl_now[SDX_CTRL_BCE];
  assign misaligned_read = ctrl_now[SDX_CTRL_READ] && blksize_reg[1:0] != 2'b00;
  assign count_limit = ctrl_now[SDX_CTRL_BCE] || block_count_field_reg == 16'h0001;
  assign block_end = blk_byte_reg == blksize_reg - 1'b1;
  assign last_byte = bytes_left_reg == 16'h0001
    || (block_end && count_limit && blk_done_reg == block_count_field_reg - 16'h0001);
  assign set_tc = (state_reg == SDX_MOVE && card_edge && last_byte && !misaligned_read)
    || (start_pulse && state_reg == SDX_IDLE && desc_reg.kind != SDX_DESC_TRANSFER_DESCRIPTOR
        && desc_reg.last);
  assign set_hazard = start_pulse && state_reg == SDX_IDLE && short_end;
  assign set_stall = state_reg == SDX_MOVE && card_edge && last_byte && misaligned_read;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SDX_IDLE;
      bytes_left_reg <= '0;
      blk_byte_reg <= '0;
      blk_done_reg <= '0;
      xfer_count_reg <= '0;
      byte_strobe <= 1'b0;
    end else begin
      byte_strobe <= 1'b0;
      case (state_reg)
        SDX_IDLE: begin
          if (start_pulse && desc_reg.kind == SDX_DESC_TRANSFER_DESCRIPTOR && desc_reg.len != 16'h0000) begin
            bytes_left_reg <= desc_reg.len;
            blk_byte_reg <= '0;
            blk_done_reg <= '0;
            xfer_count_reg <= '0;
            state_reg <= short_end ? SDX_STALL : SDX_MOVE;
          end
        end
        SDX_MOVE: begin
          if (abort_pulse) begin
            state_reg <= SDX_IDLE;
          end else if (card_edge) begin
            byte_strobe <= 1'b1;
            xfer_count_reg <= xfer_count_reg + 16'h0001;
            bytes_left_reg <= bytes_left_reg - 16'h0001;
            if (block_end) begin
              blk_byte_reg <= '0;
              blk_done_reg <= blk_done_reg + 16'h0001;
            end else begin
              blk_byte_reg <= blk_byte_reg + 1'b1;
            end
            if (last_byte) begin
              state_reg <= misaligned_read ? SDX_STALL : SDX_IDLE;
            end
          end
        end
        SDX_STALL: begin
          if (abort_pulse) begin
            state_reg <= SDX_IDLE;
          end
        end
        default: state_reg <= SDX_IDLE;
      endcase
    end
  end

  // ****************
  // Interrupt status, read clears, set wins
  // ****************
  logic [SDX_IRQ_W-1:0] status_set;
  logic status_clear;
  logic [SDX_IRQ_W-1:0] status_next;
  assign status_set = {set_stall, set_hazard, set_tc};
  assign status_clear = rd_done && paddr == SDX_OFF_IRQ_STATUS;
  // Only the bits that the read returned are cleared, so a late event is not lost.
  assign status_next = (status_clear ? status_reg & ~prdata[SDX_IRQ_W-1:0] : status_reg)
    | status_set;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
      irq <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq <= |(status_next & mask_reg);
    end
  end

  // ****************
  // APB answer
  // ****************
  logic [31:0] rd_value;
  always_comb begin
    rd_value = 32'h0000_0000;
    case (paddr)
      SDX_OFF_CTRL: rd_value = ctrl_reg;
      SDX_OFF_BLKSIZE: rd_value = 32'(blksize_reg);
      SDX_OFF_BLOCK_COUNT_FIELD: rd_value = {16'h0000, block_count_field_reg};
      SDX_OFF_DESC: rd_value = {13'h0000, desc_reg};
      SDX_OFF_PRESENT: begin
        rd_value[SDX_PRES_ACTIVE] = state_reg == SDX_MOVE;
        rd_value[SDX_PRES_LEVEL] = dat0_sync_reg[1];
      end
      SDX_OFF_IRQ_STATUS: rd_value = 32'(status_reg);
      SDX_OFF_IRQ_MASK: rd_value = 32'(mask_reg);
      SDX_OFF_XFER_COUNT: rd_value = {16'h0000, xfer_count_reg};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= SDX_RST_WORD;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase && !mapped;
      prdata <= (setup_phase && !pwrite && mapped) ? rd_value : SDX_RST_WORD;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/sdx_pkg.sv ====
// Package with the register map, field positions and types of the descriptor DMA block.
// Assumes a 32-bit APB bus and a byte-wide card data path.
`default_nettype none
package sdx_pkg;
  // ****************
  // Register offsets
  // ****************
  localparam logic [7:0] SDX_OFF_CTRL = 8'h00;
  localparam logic [7:0] SDX_OFF_BLKSIZE = 8'h04;
  localparam logic [7:0] SDX_OFF_BLOCK_COUNT_FIELD = 8'h08;
  localparam logic [7:0] SDX_OFF_DESC = 8'h0C;
  localparam logic [7:0] SDX_OFF_PRESENT = 8'h10;
  localparam logic [7:0] SDX_OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] SDX_OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] SDX_OFF_XFER_COUNT = 8'h1C;
  // ****************
  // Field positions
  // ****************
  localparam int SDX_CTRL_START = 0;
  localparam int SDX_CTRL_READ = 1;
  localparam int SDX_CTRL_BCE = 2;
  localparam int SDX_CTRL_FMT2 = 3;
  localparam int SDX_CTRL_ABORT = 4;
  localparam int SDX_PRES_ACTIVE = 2;
  localparam int SDX_PRES_LEVEL = 24;
  localparam int SDX_IRQ_TC = 0;
  localparam int SDX_IRQ_HAZARD = 1;
  localparam int SDX_IRQ_STALL = 2;
  localparam int SDX_IRQ_W = 3;
  localparam int SDX_SHORT_LEN_MAX = 4;
  // ****************
  // Reset values
  // ****************
  localparam logic [31:0] SDX_RST_WORD = 32'h0000_0000;
  localparam logic [15:0] SDX_RST_BLOCK_COUNT_FIELD = 16'h0001;
  localparam logic [11:0] SDX_RST_BLKSIZE = 12'h200;
  // ****************
  // Types
  // ****************
  typedef enum logic [1:0] {
    SDX_DESC_NOP = 2'b00,
    SDX_DESC_TRANSFER_DESCRIPTOR = 2'b10,
    SDX_DESC_LINK = 2'b11,
    SDX_DESC_RSVD = 2'b01
  } sdx_kind_t;
  typedef struct packed {
    sdx_kind_t kind;
    logic last;
    logic [15:0] len;
  } sdx_desc_t;
  typedef enum logic [1:0] {
    SDX_IDLE = 2'b00,
    SDX_MOVE = 2'b01,
    SDX_STALL = 2'b10
  } sdx_state_t;
endpackage
`default_nettype wire

// ==== verif/sdx_card_model.sv ====
// Card model: clock bursts and data line zero.
// Assumes go rises once per transfer.
`default_nettype none
module sdx_card_model (
  input wire logic [7:0] n_edges,
  input wire logic go,
  input wire logic busy,
  output logic card_clk,
  output logic card_dat0
);
  timeunit 1ns;
  timeprecision 1ps;
  // The card holds line zero low while busy.
  assign card_dat0 = !busy;
  // The clock runs only within a burst.
  initial card_clk = 1'b0;
  always @(posedge go) begin
    #3;
    repeat (n_edges) begin
      #80 card_clk = 1'b1;
      #80 card_clk = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verif/sdx_dma_bench.sv ====
// Bench of the DMA block, one task per group of scenarios.
// Assumes package, design, model and checker compiled first.
`default_nettype none
module sdx_dma_bench import sdx_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic go = 1'b0, busy = 1'b0, pready, pslverr, card_clk, card_dat0, byte_strobe, irq, er;
  logic [7:0] paddr = 8'h0, n_edges = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int err_total = 0, n_checks = 0, n_strobe = 0;
  localparam logic [31:0] ST = 32'h1 << SDX_CTRL_START, BCE = 32'h1 << SDX_CTRL_BCE;
  localparam logic [31:0] RDM = 32'h1 << SDX_CTRL_READ, F2 = 32'h1 << SDX_CTRL_FMT2;
  localparam logic [31:0] AB = 32'h1 << SDX_CTRL_ABORT;
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (byte_strobe === 1'b1) n_strobe++;
  sdx_dma u_sdx_dma (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .card_clk, .card_dat0, .byte_strobe, .irq);
  sdx_card_model u_sdx_card_model (.n_edges, .go, .busy, .card_clk, .card_dat0);
  task automatic chk(string s, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", s, exp, got);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d = 32'h0);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [31:0] dsc(sdx_kind_t k, logic [15:0] n);
    return 32'({k, 1'b1, n});
  endfunction
  task automatic xfer(string s, logic [31:0] d, bs, bc, c, sts, int e, int n);
    apb(1'b1, SDX_OFF_DESC, d);
    apb(1'b1, SDX_OFF_BLKSIZE, bs);
    apb(1'b1, SDX_OFF_BLOCK_COUNT_FIELD, bc);
    n_strobe = 0;
    apb(1'b1, SDX_OFF_CTRL, c);
    n_edges <= 8'(e);
    go <= 1'b1;
    repeat (e * 16 + 40) @(posedge pclk);
    go <= 1'b0;
    chk({s, " irq"}, 32'(sts[0]), 32'(irq));
    apb(1'b0, SDX_OFF_IRQ_STATUS);
    chk(s, sts, rd);
    if (n >= 0) chk({s, " bytes"}, 32'(n), 32'(n_strobe));
    apb(1'b1, SDX_OFF_CTRL, AB);
    chk({s, " irq clear"}, 32'h0, 32'(irq));
    $display("test %s done", s);
  endtask
  task automatic t_regs;
    apb(1'b0, SDX_OFF_BLKSIZE);
    chk("blksize", 32'(SDX_RST_BLKSIZE), rd);
    apb(1'b0, SDX_OFF_BLOCK_COUNT_FIELD);
    chk("block_count_field", 32'(SDX_RST_BLOCK_COUNT_FIELD), rd);
    apb(1'b1, 8'h20);
    chk("unmapped", 32'h1, 32'(er));
    apb(1'b1, SDX_OFF_IRQ_MASK, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_move;
    xfer("move", dsc(SDX_DESC_TRANSFER_DESCRIPTOR, 16'h8), 32'h4, 32'h2, ST | BCE, 32'h1, 8, 8);
  endtask
  task automatic t_short;
    xfer("short", dsc(SDX_DESC_TRANSFER_DESCRIPTOR, 16'h4), 32'h4, 32'h1, ST | BCE | F2, 32'h2, 4, 0);
    xfer("short1", dsc(SDX_DESC_TRANSFER_DESCRIPTOR, 16'h4), 32'h4, 32'h1, ST | BCE, 32'h2, 4, 0);
    xfer("nobce", dsc(SDX_DESC_TRANSFER_DESCRIPTOR, 16'h4), 32'h4, 32'h1, ST, 32'h1, 4, 4);
  endtask
  task automatic t_nop;
    xfer("nop", dsc(SDX_DESC_NOP, 16'h0), 32'h4, 32'h1, ST, 32'h1, 0, 0);
  endtask
  task automatic t_odd;
    xfer("odd", dsc(SDX_DESC_TRANSFER_DESCRIPTOR, 16'hC), 32'h6, 32'h2, ST | BCE | RDM, 32'h4, 12, 12);
  endtask
  task automatic t_pad;
    xfer("pad", dsc(SDX_DESC_TRANSFER_DESCRIPTOR, 16'h10), 32'h8, 32'h2, ST | BCE | RDM, 32'h1, 16, 16);
  endtask
  task automatic t_count;
    xfer("one", dsc(SDX_DESC_TRANSFER_DESCRIPTOR, 16'h8), 32'h4, 32'h1, ST, 32'h1, 8, 4);
    xfer("max", dsc(SDX_DESC_TRANSFER_DESCRIPTOR, 16'h8), 32'h4, 32'hFFFF, ST | BCE, 32'h1, 8, 8);
  endtask
  task automatic t_busy;
    busy <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, SDX_OFF_PRESENT);
    chk("busy", 32'h0, rd & 32'h0100_0004);
    busy <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b0, SDX_OFF_PRESENT);
    chk("free", 32'h0100_0000, rd & 32'h0100_0004);
    $display("test busy done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_move();
    t_short();
    t_nop();
    t_odd();
    t_pad();
    t_count();
    t_busy();
    final_report();
  end
  initial begin
    #100us;
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire

// ==== verif/sdx_dma_properties.sv ====
// Port checker of the DMA block.
// Assumes it is bound to sdx_dma.
`default_nettype none
module sdx_dma_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Card and interrupt
  input wire logic card_clk,
  input wire logic card_dat0,
  input wire logic byte_strobe,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic su = psel && !penable;
  wire logic rs = su && !pwrite;
  chk_ready_next: assert property (su |=> pready) else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready long");
  chk_err_unmapped: assert property (su && paddr > 8'h1C |=> pslverr) else $error("no pslverr");
  chk_err_mapped: assert property (su && paddr < 8'h20 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("bad pslverr");
  chk_data_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
  chk_start_zero: assert property (rs && paddr == 8'h00 |=> !prdata[0]) else $error("start");
  chk_strobe_pulse: assert property (byte_strobe |=> !byte_strobe) else $error("strobe");
  chk_strobe_clock: assert property (byte_strobe |-> card_clk) else $error("stray");
  chk_level_bit: assert property ($stable(card_dat0)[*5] ##0 (rs && paddr == 8'h10) |=>
    prdata[24] == card_dat0) else $error("level bit");
  cov_strobe: cover property (byte_strobe);
  cov_irq: cover property ($rose(irq));
  cov_err: cover property (pslverr);
endmodule
bind sdx_dma sdx_dma_properties u_sdx_dma_properties (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .card_clk, .card_dat0, .byte_strobe, .irq);
`default_nettype wire
